/* verilog/mcs_top.sv */
`timescale 1ns/1ps
module mcs_top #(
    parameter int BLINK_HALF_TICKS = mcs_pkg::BLINK_HALF_US,
    parameter int CAN_HOLD_TICKS   = mcs_pkg::CAN_HOLD_US,
    parameter int DISC_TICKS       = mcs_pkg::DISC_US,
    parameter int SUPERVISE_TICKS  = mcs_pkg::SUPERVISE_US
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [5:0]  joint_home_input,
    input  wire logic [5:0]  joint_lower_limit_input,
    input  wire logic [5:0]  joint_upper_limit_input,
    input  wire logic [1:0]  estop_input,
    input  wire logic        power_fault_input,
    input  wire logic        can_traffic,
    input  wire logic        can_buffer_full,
    input  wire logic        node_answer,
    input  wire logic [3:0]  node_answer_addr,
    output logic      [6:0]  amp_power_en,
    output logic             error_indicator,
    output logic             can_indicator,
    output logic             rs485_indicator,
    output logic             app_running_indicator,
    output logic             boot_indicator
);

    localparam logic [6:0]  TICK_LAST  = 7'(mcs_pkg::US_CYCLES - 1);
    localparam logic [19:0] BLINK_LAST = 20'(BLINK_HALF_TICKS - 1);
    localparam logic [19:0] CAN_HOLD   = 20'(CAN_HOLD_TICKS);
    localparam logic [19:0] DISC_LAST  = 20'(DISC_TICKS - 1);
    localparam logic [19:0] SUP_LAST   = 20'(SUPERVISE_TICKS - 1);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [mcs_pkg::SYNC_W-1:0] pins_sync;
    logic [5:0]   home_s;
    logic [5:0]   lower_s;
    logic [5:0]   upper_s;
    logic [1:0]   estop_s;
    logic         fault_s;
    logic [6:0]   tick_cnt_reg;
    logic         us_tick_reg;
    logic [4:0]   ctrl_reg;
    logic [31:0]  timeout_reg;
    logic [31:0]  wd_cnt_reg;
    logic         expired_reg;
    logic [31:0]  snap_reg;
    logic [31:0]  rd_mux;
    logic [31:0]  live_inputs;
    logic         bus_req;
    logic         accept;
    logic         wr_ctrl;
    logic         wr_timeout;
    logic         wr_node_ctrl;
    logic [4:0]   ctrl_next;
    logic         arm_rise;
    logic         kick;
    logic         wd_set;
    logic [19:0]  blink_cnt_reg;
    logic         blink_reg;
    logic [19:0]  can_hold_reg;
    mcs_pkg::mcs_rs_e rs_state_reg;
    logic [19:0]  win_cnt_reg;
    logic [15:0]  known_reg;
    logic [15:0]  active_reg;
    logic [15:0]  alive_reg;
    logic         dropped_reg;
    logic [15:0]  answer_vec;
    logic         scan_req;
    logic         win_end;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    mcs_sync #(
        .WIDTH (mcs_pkg::SYNC_W)
    ) u_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in ({power_fault_input, estop_input,
                    joint_upper_limit_input, joint_lower_limit_input,
                    joint_home_input}),
        .sync_out (pins_sync)
    );

    assign home_s  = pins_sync[5:0];
    assign lower_s = pins_sync[11:6];
    assign upper_s = pins_sync[17:12];
    assign estop_s = pins_sync[19:18];
    assign fault_s = pins_sync[20];

    always_comb begin
        live_inputs = '0;
        live_inputs[mcs_pkg::IN_HOME_LSB  +: 6] = home_s;
        live_inputs[mcs_pkg::IN_LOWER_LSB +: 6] = lower_s;
        live_inputs[mcs_pkg::IN_UPPER_LSB +: 6] = upper_s;
        live_inputs[mcs_pkg::IN_ESTOP_LSB +: 2] = estop_s;
    end

    // ****************************************************************
    // microsecond tick
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt_reg <= '0;
            us_tick_reg  <= 1'b0;
        end else begin
            us_tick_reg <= (tick_cnt_reg == TICK_LAST);
            if (tick_cnt_reg == TICK_LAST) begin
                tick_cnt_reg <= '0;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 7'h01;
            end
        end
    end

    // ****************************************************************
    // avalon slave
    // ****************************************************************
    assign bus_req      = avs_read | avs_write;
    assign accept       = bus_req & ~avs_waitrequest;
    assign wr_ctrl      = accept & avs_write
                        & (avs_address == mcs_pkg::OFF_CTRL);
    assign wr_timeout   = accept & avs_write
                        & (avs_address == mcs_pkg::OFF_WD_TIMEOUT);
    assign wr_node_ctrl = accept & avs_write
                        & (avs_address == mcs_pkg::OFF_NODE_CTRL);
    assign ctrl_next    = 5'(lane_merge({27'h0, ctrl_reg},
                                        avs_writedata, avs_byteenable));
    assign arm_rise     = wr_ctrl & ctrl_next[mcs_pkg::CTRL_WD_ARM]
                        & ~ctrl_reg[mcs_pkg::CTRL_WD_ARM];
    assign kick         = accept & avs_read
                        & (avs_address == mcs_pkg::OFF_INPUTS);
    assign scan_req     = wr_node_ctrl & avs_byteenable[0]
                        & avs_writedata[mcs_pkg::NODE_CTRL_SCAN];

    // one wait cycle, then a single cycle with waitrequest low
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_waitrequest && bus_req) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        rd_mux = '0;
        unique case (avs_address)
            mcs_pkg::OFF_CTRL:       rd_mux = {27'h0, ctrl_reg};
            mcs_pkg::OFF_WD_TIMEOUT: rd_mux = timeout_reg;
            mcs_pkg::OFF_STATUS: begin
                rd_mux[mcs_pkg::ST_WD_EXPIRED]   = expired_reg;
                rd_mux[mcs_pkg::ST_POWER_FAULT]  = fault_s;
                rd_mux[mcs_pkg::ST_POWER_ON]     = amp_power_en[0];
                rd_mux[mcs_pkg::ST_NODE_DROPPED] = dropped_reg;
                rd_mux[mcs_pkg::ST_DISCOVERY]    =
                    (rs_state_reg == mcs_pkg::MCS_RS_DISC);
                rd_mux[mcs_pkg::ST_CAN_FULL]     = can_buffer_full;
            end
            mcs_pkg::OFF_INPUTS:     rd_mux = live_inputs;
            mcs_pkg::OFF_INPUTS_N:   rd_mux = ~snap_reg
                                     & 32'h033f3f3f;
            mcs_pkg::OFF_NODES:      rd_mux = {active_reg, known_reg};
            default:                 rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= '0;
        end else if (avs_waitrequest && avs_read) begin
            avs_readdata <= rd_mux;
        end
    end

    // snapshot taken with the same value the periodic read returns
    always_ff @(posedge clk) begin
        if (srst) begin
            snap_reg <= '0;
        end else if (avs_waitrequest && avs_read
                     && avs_address == mcs_pkg::OFF_INPUTS) begin
            snap_reg <= live_inputs;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= mcs_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timeout_reg <= mcs_pkg::WD_TIMEOUT_RST;
        end else if (wr_timeout) begin
            timeout_reg <= lane_merge(timeout_reg, avs_writedata,
                                      avs_byteenable);
        end
    end

    // ****************************************************************
    // watchdog
    // ****************************************************************
    // only a fresh expiry beats a kick; a saturated count would block it
    assign wd_set = ctrl_reg[mcs_pkg::CTRL_WD_ARM] & ~expired_reg
                  & (wd_cnt_reg >= timeout_reg);

    always_ff @(posedge clk) begin
        if (srst) begin
            wd_cnt_reg <= '0;
        end else if (kick || arm_rise
                     || !ctrl_reg[mcs_pkg::CTRL_WD_ARM]) begin
            wd_cnt_reg <= '0;
        end else if (us_tick_reg && wd_cnt_reg != 32'hffffffff) begin
            wd_cnt_reg <= wd_cnt_reg + 32'h00000001;
        end
    end

    // an expiry in the clearing cycle still sets the flag
    always_ff @(posedge clk) begin
        if (srst) begin
            expired_reg <= 1'b0;
        end else if (wd_set) begin
            expired_reg <= 1'b1;
        end else if (kick || arm_rise) begin
            expired_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            amp_power_en <= '0;
        end else begin
            amp_power_en <= {mcs_pkg::AMP_OUTS{
                ctrl_reg[mcs_pkg::CTRL_POWER_REQ]
                & ~expired_reg & ~wd_set & ~fault_s}};
        end
    end

    // ****************************************************************
    // blink and CAN activity timers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            blink_cnt_reg <= '0;
            blink_reg     <= 1'b0;
        end else if (us_tick_reg) begin
            if (blink_cnt_reg == BLINK_LAST) begin
                blink_cnt_reg <= '0;
                blink_reg     <= ~blink_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 20'h00001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            can_hold_reg <= '0;
        end else if (can_traffic) begin
            can_hold_reg <= CAN_HOLD;
        end else if (us_tick_reg && can_hold_reg != 20'h00000) begin
            can_hold_reg <= can_hold_reg - 20'h00001;
        end
    end

    // ****************************************************************
    // expander node supervision
    // ****************************************************************
    assign answer_vec = node_answer ? (16'h0001 << node_answer_addr)
                                    : 16'h0000;
    assign win_end    = us_tick_reg
                      & (win_cnt_reg == ((rs_state_reg == mcs_pkg::MCS_RS_DISC)
                                         ? DISC_LAST : SUP_LAST));

    always_ff @(posedge clk) begin
        if (srst || scan_req) begin
            win_cnt_reg <= '0;
        end else if (win_end) begin
            win_cnt_reg <= '0;
        end else if (us_tick_reg) begin
            win_cnt_reg <= win_cnt_reg + 20'h00001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || scan_req) begin
            rs_state_reg <= mcs_pkg::MCS_RS_DISC;
            known_reg    <= '0;
            active_reg   <= '0;
            alive_reg    <= '0;
            dropped_reg  <= 1'b0;
        end else begin
            unique case (rs_state_reg)
                mcs_pkg::MCS_RS_DISC: begin
                    known_reg <= known_reg | answer_vec;
                    if (win_end) begin
                        rs_state_reg <= mcs_pkg::MCS_RS_RUN;
                        active_reg   <= known_reg | answer_vec;
                        alive_reg    <= '0;
                    end
                end
                mcs_pkg::MCS_RS_RUN: begin
                    if (win_end) begin
                        active_reg  <= active_reg
                                     & (alive_reg | answer_vec);
                        dropped_reg <= dropped_reg
                                     | (|(active_reg
                                     & ~(alive_reg | answer_vec)));
                        alive_reg   <= '0;
                    end else begin
                        alive_reg <= alive_reg | answer_vec;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // indicators
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            error_indicator       <= 1'b0;
            can_indicator         <= 1'b0;
            rs485_indicator       <= 1'b0;
            app_running_indicator <= 1'b0;
            boot_indicator        <= 1'b0;
        end else begin
            error_indicator <= expired_reg
                | (ctrl_reg[mcs_pkg::CTRL_LINK_ERR] & blink_reg);
            can_indicator   <= can_buffer_full
                | ((can_hold_reg != 20'h00000) & blink_reg);
            rs485_indicator <= (rs_state_reg == mcs_pkg::MCS_RS_DISC)
                ? blink_reg
                : (~dropped_reg & (active_reg != 16'h0000));
            app_running_indicator <= ctrl_reg[mcs_pkg::CTRL_APP_RUN]
                & blink_reg;
            boot_indicator  <= ctrl_reg[mcs_pkg::CTRL_BOOT_DONE];
        end
    end

endmodule

/* verilog/mcs_pkg.sv */
// Operation
// - the periodic input read restarts the watchdog; nothing else kicks it (a rising arm bit also restarts the count here)
// - watchdog overrun forces every amplifier power enable low in hardware
// - a readable status flag shows that the watchdog has expired
// - software can arm and disarm the watchdog through a read/write control
// - power enables high only with request, live watchdog and no power fault
// - error light off without fault, blinks on link error, on when expired
// - CAN light blinks on traffic, on when a buffer is full, else off
// - RS485 light blinks discovering, on while nodes answer, off after drop
// - application light blinks while the host application runs, else off
// - boot light on only after a successful boot
// - every node answering on the expander bus in discovery is recognised
// - a node that stops answering regularly leaves the active set
// - six joints sample home and two limit inputs on the read, with inverses
// - two emergency stop inputs are sampled and shown with inverted copies
package mcs_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_NS         = 8;
    localparam int US_NS          = 1000;
    localparam int US_CYCLES      = US_NS / CLK_NS;
    localparam int BLINK_HALF_US  = 250000;
    localparam int CAN_HOLD_US    = 20000;
    localparam int DISC_US        = 500000;
    localparam int SUPERVISE_US   = 50000;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_WD_TIMEOUT = 8'h04;
    localparam logic [7:0] OFF_STATUS     = 8'h08;
    localparam logic [7:0] OFF_INPUTS     = 8'h0c;
    localparam logic [7:0] OFF_INPUTS_N   = 8'h10;
    localparam logic [7:0] OFF_NODES      = 8'h14;
    localparam logic [7:0] OFF_NODE_CTRL  = 8'h18;

    localparam int CTRL_WD_ARM     = 0;
    localparam int CTRL_POWER_REQ  = 1;
    localparam int CTRL_APP_RUN    = 2;
    localparam int CTRL_BOOT_DONE  = 3;
    localparam int CTRL_LINK_ERR   = 4;
    localparam int CTRL_W          = 5;

    localparam int ST_WD_EXPIRED   = 0;
    localparam int ST_POWER_FAULT  = 1;
    localparam int ST_POWER_ON     = 2;
    localparam int ST_NODE_DROPPED = 3;
    localparam int ST_DISCOVERY    = 4;
    localparam int ST_CAN_FULL     = 5;

    localparam int IN_HOME_LSB     = 0;
    localparam int IN_LOWER_LSB    = 8;
    localparam int IN_UPPER_LSB    = 16;
    localparam int IN_ESTOP_LSB    = 24;
    localparam int NODES_ACT_LSB   = 16;
    localparam int NODE_CTRL_SCAN  = 0;

    localparam logic [4:0]  CTRL_RST       = 5'h00;
    localparam logic [31:0] WD_TIMEOUT_RST = 32'h00000bb8;

    localparam int JOINTS     = 6;
    localparam int ESTOPS     = 2;
    localparam int NODES      = 16;
    localparam int AMP_OUTS   = 7;
    localparam int SYNC_W     = 3 * JOINTS + ESTOPS + 1;

    typedef enum logic [1:0] {
        MCS_RS_DISC = 2'b01,
        MCS_RS_RUN  = 2'b10
    } mcs_rs_e;

endpackage

/* verilog/mcs_sync.sv */
`timescale 1ns/1ps
module mcs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // ****************************************************************
    // two stage synchroniser
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* test/mcs_node_model.sv */
`timescale 1ns/1ps
// ************
// expander nodes, one answer slot per address
// ************
module mcs_node_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [15:0] node_on,
    output logic             node_answer,
    output logic      [3:0]  node_answer_addr
);
    logic [6:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end

    // each address owns its own slot, so two nodes never share one
    always_ff @(posedge clk) begin
        node_answer_addr <= cnt_reg[6:3];
        // a node switched off has gone to its error state and is silent
        node_answer      <= (cnt_reg[2:0] == 3'h0)
                            && node_on[cnt_reg[6:3]];
    end
endmodule

/* test/mcs_top_asserts.sv */
`timescale 1ns/1ps
// ************
// bus and power checks
// ************
module mcs_top_chk (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        power_fault_input,
    input wire logic [6:0]  amp_power_en,
    input wire logic        error_indicator,
    input wire logic        boot_indicator
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_wait_one: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_amp_uniform: assert property (
        amp_power_en == 7'h00 || amp_power_en == 7'h7f)
        else $error("power enables disagree");
    a_fault_power: assert property (
        power_fault_input [*4] |-> amp_power_en == 7'h00)
        else $error("power enabled during power fault");
    a_reset_dark: assert property (
        $fell(srst) |-> amp_power_en == 7'h00 && !boot_indicator
            && !error_indicator)
        else $error("outputs lit out of reset");
    a_reset_bus: assert property (
        $fell(srst) |-> avs_waitrequest && avs_readdata == 32'h00000000)
        else $error("bus outputs wrong out of reset");

    c_power_on: cover property (amp_power_en == 7'h7f);
    c_power_cut: cover property ($fell(amp_power_en[0]));
    c_error_lit: cover property ($rose(error_indicator));
endmodule

/* test/mcs_top_tb.sv */
`timescale 1ns/1ps
module mcs_top_tb;
    // ************
    // signals and instances
    // ************
    logic        clk;
    logic        srst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  joint_home_input;
    logic [5:0]  joint_lower_limit_input;
    logic [5:0]  joint_upper_limit_input;
    logic [1:0]  estop_input;
    logic        power_fault_input;
    logic        can_traffic;
    logic        can_buffer_full;
    logic        node_answer;
    logic [3:0]  node_answer_addr;
    logic [6:0]  amp_power_en;
    logic        error_indicator;
    logic        can_indicator;
    logic        rs485_indicator;
    logic        app_running_indicator;
    logic        boot_indicator;
    logic [15:0] node_on;
    logic [31:0] q;
    logic [31:0] snap;
    logic [4:0]  ind;
    int          n_mismatch;
    int          comparisons;
    int          tg;

    assign ind = {error_indicator, can_indicator, rs485_indicator,
                  app_running_indicator, boot_indicator};

    mcs_top #(.BLINK_HALF_TICKS(4), .CAN_HOLD_TICKS(8), .DISC_TICKS(20),
              .SUPERVISE_TICKS(10)) DUT (
        .clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .joint_home_input,
        .joint_lower_limit_input, .joint_upper_limit_input, .estop_input,
        .power_fault_input, .can_traffic, .can_buffer_full, .node_answer,
        .node_answer_addr, .amp_power_en, .error_indicator, .can_indicator,
        .rs485_indicator, .app_running_indicator, .boot_indicator);

    mcs_node_model u_nodes (
        .clk, .srst, .node_on, .node_answer, .node_answer_addr);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ************
    // tasks
    // ************
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 64);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (i >= 64) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h00000000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // m = 2 expects blinking, otherwise a steady level of m
    task automatic look(input string nm, input int k, input int m);
        logic v;
        tg = 0;
        v = ind[k];
        repeat (1200) begin
            @(posedge clk);
            if (ind[k] !== v) tg++;
            v = ind[k];
        end
        chk(nm, m, (tg > 0) ? 32'h2 : {31'h0, ind[k]});
    endtask

    task automatic shake;
        joint_home_input        <= 6'($urandom);
        joint_lower_limit_input <= 6'($urandom);
        joint_upper_limit_input <= 6'($urandom);
        estop_input             <= 2'($urandom);
        cyc(5);
    endtask

    function automatic logic [31:0] pins;
        return {6'h00, estop_input, 2'h0, joint_upper_limit_input, 2'h0,
                joint_lower_limit_input, 2'h0, joint_home_input};
    endfunction

    // ************
    // sequence
    // ************
    initial begin
        void'($urandom(32'h5357498c));
        srst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        {joint_home_input, joint_lower_limit_input} = '0;
        {joint_upper_limit_input, estop_input} = '0;
        {power_fault_input, can_traffic, can_buffer_full} = '0;
        n_mismatch = 0;
        comparisons = 0;
        node_on = 16'($urandom) | 16'h0008;
        cyc(6);
        srst <= 1'b0;
        rd(mcs_pkg::OFF_CTRL);
        chk("ctrl", 0, q);
        rd(mcs_pkg::OFF_WD_TIMEOUT);
        chk("timeout", mcs_pkg::WD_TIMEOUT_RST, q);
        rd(8'h1c);
        chk("unmapped", 0, q);
        wr(mcs_pkg::OFF_STATUS, 32'hffffffff);
        rd(mcs_pkg::OFF_STATUS);
        chk("status", 32'h10, q & 32'h3f);
        avs_byteenable <= 4'h1;
        wr(mcs_pkg::OFF_WD_TIMEOUT, 32'hffffff05);
        avs_byteenable <= 4'hf;
        rd(mcs_pkg::OFF_WD_TIMEOUT);
        chk("timeout lane", 32'h0b05, q);
        look("rs485 disc", 2, 2);
        cyc(1400);
        rd(mcs_pkg::OFF_NODES);
        chk("nodes", {node_on, node_on}, q);
        look("rs485 run", 2, 1);
        shake();
        rd(mcs_pkg::OFF_INPUTS);
        snap = pins();
        chk("inputs", snap, q);
        shake();
        rd(mcs_pkg::OFF_INPUTS_N);
        chk("inputs_n", ~snap & 32'h033f3f3f, q);
        wr(mcs_pkg::OFF_WD_TIMEOUT, 32'h5);
        wr(mcs_pkg::OFF_CTRL, 32'hf);
        repeat (6) begin
            rd(mcs_pkg::OFF_INPUTS);
            cyc(200);
            chk("amp kicked", 32'h7f, amp_power_en);
        end
        chk("boot", 1, boot_indicator);
        repeat (6) begin
            rd(mcs_pkg::OFF_CTRL);
            cyc(200);
        end
        chk("amp expired", 0, amp_power_en);
        look("err on", 4, 1);
        wr(mcs_pkg::OFF_CTRL, 32'he);
        rd(mcs_pkg::OFF_STATUS);
        chk("expired held", 1, q & 32'h1);
        chk("amp held", 0, amp_power_en);
        rd(mcs_pkg::OFF_INPUTS);
        rd(mcs_pkg::OFF_STATUS);
        chk("kick clears", 0, q & 32'h1);
        cyc(3);
        chk("amp back", 32'h7f, amp_power_en);
        power_fault_input <= 1'b1;
        cyc(6);
        chk("amp fault", 0, amp_power_en);
        rd(mcs_pkg::OFF_STATUS);
        chk("fault flag", 2, q & 32'h7);
        power_fault_input <= 1'b0;
        look("app blink", 1, 2);
        look("err off", 4, 0);
        look("can idle", 3, 0);
        wr(mcs_pkg::OFF_CTRL, 32'h1e);
        look("err blink", 4, 2);
        wr(mcs_pkg::OFF_CTRL, 32'h0);
        look("app off", 1, 0);
        chk("boot off", 0, boot_indicator);
        fork
            look("can blink", 3, 2);
            repeat (12) begin
                @(posedge clk);
                can_traffic <= 1'b1;
                @(posedge clk);
                can_traffic <= 1'b0;
                cyc(98);
            end
        join
        can_buffer_full <= 1'b1;
        cyc(4);
        look("can full", 3, 1);
        can_buffer_full <= 1'b0;
        node_on[3] <= 1'b0;
        cyc(4000);
        rd(mcs_pkg::OFF_NODES);
        chk("nodes drop", {node_on, node_on | 16'h0008}, q);
        look("rs485 drop", 2, 0);
        wr(mcs_pkg::OFF_NODE_CTRL, 32'h1);
        look("rs485 rescan", 2, 2);
        wr(mcs_pkg::OFF_CTRL, 32'h3);
        cyc(1000);
        rd(mcs_pkg::OFF_INPUTS);
        rd(mcs_pkg::OFF_STATUS);
        chk("armed kick", 0, q & 32'h1);
        end_sim();
    end

    initial begin
        cyc(100000);
        n_mismatch++;
        end_sim();
    end
endmodule

bind mcs_top mcs_top_chk u_chk (
    .clk, .srst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .power_fault_input, .amp_power_en, .error_indicator, .boot_indicator);
